/* hdl/retimer_params.svh */
// register offsets, field positions and reset values of the retimer
// register bank; definitions only, included by the design modules
`ifndef RETIMER_PARAMS_SVH
`define RETIMER_PARAMS_SVH

// shared set offsets
`define OFS_BUS_ADDRESS_STRAP   8'h00
`define OFS_REVISION_AND_PART   8'h01
`define OFS_SHARED_CONTROL      8'h04
`define OFS_REGISTER_SET_SELECT 8'hff

// channel set offsets
`define OFS_CHANNEL_SCRATCH     8'h00
`define OFS_DEEMPHASIS_CONTROL  8'h15

// select register fields
`define SEL_CHAN_LSB            0
`define SEL_CHAN_MSB            1
`define SEL_CHANNEL_ENABLE_BIT  2
`define SEL_BROADCAST_BIT       3

// strap register: pins sit in bits 7:4, bits 3:0 reserved
`define STRAP_LSB               4
`define SLAVE_ADDR_BASE         7'h18

// shared control self-clearing fields
`define CTRL_RESET_SHARED_BIT   6
`define CTRL_RESET_MASTER_BIT   5

// de-emphasis field layout
`define DEEMPH_CODE_MSB         2
`define DEEMPH_RANGE_BIT        6

// reset values
`define RST_SELECT              8'h00
`define RST_STRAP               4'h0
`define RST_SHARED_CONTROL      8'h01
`define RST_CHANNEL_SCRATCH     8'h00
`define RST_DEEMPHASIS          8'h00

// value returned for a read of the select register and unmapped offsets
`define READ_INVALID            8'h00
`define READ_UNMAPPED           8'h00

`endif

/* hdl/retimer_pkg.sv */
// types shared by the retimer register bank and its channel sets
// assumes retimer_params.svh for the numeric constants
package retimer_pkg;

    // one register access taken from the smbus protocol engine
    typedef struct packed {
        logic       wrEn;
        logic       rdEn;
        logic [7:0] addr;
        logic [7:0] wdata;
    } regAccess_s;

    // decoded driver de-emphasis of one channel
    typedef struct packed {
        logic       range;
        logic [2:0] code;
        logic [3:0] index;    // 0 = 0 dB .. 14 = -12.0 dB, by depth
        logic [7:0] tenthsDb; // magnitude in tenths of a dB
    } deemph_s;

endpackage

/* hdl/retimer_channel_set.sv */
// one channel register set: scratch register 0x00 and de-emphasis deemphasis_control,
// with the de-emphasis setting decoded into a registered output
// assumes a reset already synchronised to clk by the caller
`timescale 1ns/1ps
`include "retimer_params.svh"

module retimer_channel_set
    import retimer_pkg::*;
(
    input  wire logic       clk,
    input  wire logic       rst_n,
    input  wire logic       wrEn,
    input  wire logic [7:0] addr,
    input  wire logic [7:0] wdata,
    output logic      [7:0] rdData,
    output deemph_s         deemph
);

    logic [7:0] scratch_ff;
    logic [7:0] nxt_scratch;
    logic [7:0] deemphReg_ff;
    logic [7:0] nxt_deemphReg;
    deemph_s    deemph_ff;
    deemph_s    nxt_deemph;

    // table lookup: range 1 gives the fine steps, range 0 the coarse ones
    function automatic deemph_s decode(input logic [7:0] r);
        deemph_s d;
        d.range = r[`DEEMPH_RANGE_BIT];
        d.code  = r[`DEEMPH_CODE_MSB:0];
        d.index = 4'h0;
        d.tenthsDb = 8'h00;
        if (d.range)
        begin
            unique case (d.code)
                3'h0: begin d.index = 4'h0; d.tenthsDb = 8'h00; end
                3'h1: begin d.index = 4'h1; d.tenthsDb = 8'h09; end
                3'h2: begin d.index = 4'h3; d.tenthsDb = 8'h14; end
                3'h3: begin d.index = 4'h4; d.tenthsDb = 8'h1c; end
                3'h4: begin d.index = 4'h5; d.tenthsDb = 8'h21; end
                3'h5: begin d.index = 4'h7; d.tenthsDb = 8'h27; end
                3'h6: begin d.index = 4'h8; d.tenthsDb = 8'h2d; end
                3'h7: begin d.index = 4'ha; d.tenthsDb = 8'h38; end
            endcase
        end
        else
        begin
            unique case (d.code)
                3'h0: begin d.index = 4'h0; d.tenthsDb = 8'h00; end
                3'h1: begin d.index = 4'h2; d.tenthsDb = 8'h0f; end
                3'h2: begin d.index = 4'h6; d.tenthsDb = 8'h23; end
                3'h3: begin d.index = 4'h9; d.tenthsDb = 8'h32; end
                3'h4: begin d.index = 4'hb; d.tenthsDb = 8'h3c; end
                3'h5: begin d.index = 4'hc; d.tenthsDb = 8'h4b; end
                3'h6: begin d.index = 4'hd; d.tenthsDb = 8'h5a; end
                3'h7: begin d.index = 4'he; d.tenthsDb = 8'h78; end
            endcase
        end
        return d;
    endfunction

    // only the documented de-emphasis bits are kept; the rest read zero
    always_comb
    begin
        nxt_scratch   = scratch_ff;
        nxt_deemphReg = deemphReg_ff;
        if (wrEn && addr == `OFS_CHANNEL_SCRATCH)
            nxt_scratch = wdata;
        if (wrEn && addr == `OFS_DEEMPHASIS_CONTROL)
        begin
            nxt_deemphReg = 8'h00;
            nxt_deemphReg[`DEEMPH_RANGE_BIT] = wdata[`DEEMPH_RANGE_BIT];
            nxt_deemphReg[`DEEMPH_CODE_MSB:0] = wdata[`DEEMPH_CODE_MSB:0];
        end
        nxt_deemph = decode(nxt_deemphReg);
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            scratch_ff   <= `RST_CHANNEL_SCRATCH;
            deemphReg_ff <= `RST_DEEMPHASIS;
            deemph_ff    <= '0;
        end
        else
        begin
            scratch_ff   <= nxt_scratch;
            deemphReg_ff <= nxt_deemphReg;
            deemph_ff    <= nxt_deemph;
        end
    end

    // read mux of this set; the caller registers the result
    always_comb
    begin
        unique case (addr)
            `OFS_CHANNEL_SCRATCH:    rdData = scratch_ff;
            `OFS_DEEMPHASIS_CONTROL: rdData = deemphReg_ff;
            default:                 rdData = `READ_UNMAPPED;
        endcase
    end

    assign deemph = deemph_ff;

endmodule

/* hdl/retimer_shared_channel_regs.sv */
// register bank of a four-channel retimer: shared set, select register
// and four channel sets, reached by byte accesses from the smbus engine
// assumes the smbus engine presents one access per pulse on clk
`timescale 1ns/1ps
`include "retimer_params.svh"

module retimer_shared_channel_regs
    import retimer_pkg::*;
#(
    // identity byte of the revision_and_part register; value is arbitrary
    parameter logic [7:0] REVISION_AND_PART = 8'h5a
)
(
    input  wire logic       clk,
    input  wire logic       arst_n,
    input  regAccess_s      access,
    input  wire logic [3:0] addrStrapPin,
    output logic      [7:0] rdData,
    output logic            rdValid,
    output logic      [6:0] slaveAddr,
    output logic      [7:0] selectState,
    output deemph_s   [3:0] deemph
);

    localparam int NUM_CHAN = 4;

    // reset release through two flops; assertion stays asynchronous
    logic       rstMeta_ff;
    logic       rstSync_ff;

    // strap pins cross in from the board, two flops before any use
    logic [3:0] strapMeta_ff;
    logic [3:0] strapSync_ff;

    logic [7:0] select_ff;
    logic [7:0] nxt_select;
    logic [7:0] control_ff;
    logic [7:0] nxt_control;
    logic [3:0] strap_ff;
    logic [3:0] nxt_strap;
    logic [6:0] slaveAddr_ff;
    logic [6:0] nxt_slaveAddr;
    logic [7:0] rdData_ff;
    logic [7:0] nxt_rdData;
    logic       rdValid_ff;
    logic       nxt_rdValid;

    logic [1:0] selChan;
    logic       chanMode;
    logic       broadcast;
    logic       selWrite;
    logic [NUM_CHAN-1:0] chanWr;
    logic [7:0] chanRd [NUM_CHAN];
    logic [7:0] sharedRd;

    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            rstMeta_ff <= 1'b0;
            rstSync_ff <= 1'b0;
        end
        else
        begin
            rstMeta_ff <= 1'b1;
            rstSync_ff <= rstMeta_ff;
        end
    end

    always_ff @(posedge clk or negedge rstSync_ff)
    begin
        if (!rstSync_ff)
        begin
            strapMeta_ff <= `RST_STRAP;
            strapSync_ff <= `RST_STRAP;
        end
        else
        begin
            strapMeta_ff <= addrStrapPin;
            strapSync_ff <= strapMeta_ff;
        end
    end

    // routing decoded from the select register
    assign selChan   = select_ff[`SEL_CHAN_MSB:`SEL_CHAN_LSB];
    assign chanMode  = select_ff[`SEL_CHANNEL_ENABLE_BIT];
    assign broadcast = chanMode && select_ff[`SEL_BROADCAST_BIT];
    // register_set_select is never forwarded to any channel set
    assign selWrite  = access.wrEn &&
                       access.addr == `OFS_REGISTER_SET_SELECT;

    // per-channel write strobes; broadcast overrides the channel number
    always_comb
    begin
        chanWr = '0;
        if (access.wrEn && !selWrite && chanMode)
        begin
            for (int i = 0; i < NUM_CHAN; i++)
                chanWr[i] = broadcast || (selChan == i[1:0]);
        end
    end

    // shared set writes, self-clearing fields and the strap capture
    always_comb
    begin
        nxt_select  = select_ff;
        nxt_control = control_ff;
        // self-clearing bits drop back after one cycle
        nxt_control[`CTRL_RESET_SHARED_BIT] = 1'b0;
        nxt_control[`CTRL_RESET_MASTER_BIT] = 1'b0;
        // a pending shared reset returns select and control to defaults; a write in that cycle wins
        if (control_ff[`CTRL_RESET_SHARED_BIT])
        begin
            nxt_select  = `RST_SELECT;
            nxt_control = `RST_SHARED_CONTROL;
        end
        if (selWrite)
            nxt_select = access.wdata;
        else if (access.wrEn && !chanMode
                 && access.addr == `OFS_SHARED_CONTROL)
            nxt_control = access.wdata;
        // strap and identity offsets keep no write path at all
        nxt_strap     = strapSync_ff;
        nxt_slaveAddr = `SLAVE_ADDR_BASE + {3'h0, strapSync_ff};
    end

    always_ff @(posedge clk or negedge rstSync_ff)
    begin
        if (!rstSync_ff)
        begin
            select_ff    <= `RST_SELECT;
            control_ff   <= `RST_SHARED_CONTROL;
            strap_ff     <= `RST_STRAP;
            slaveAddr_ff <= `SLAVE_ADDR_BASE;
        end
        else
        begin
            select_ff    <= nxt_select;
            control_ff   <= nxt_control;
            strap_ff     <= nxt_strap;
            slaveAddr_ff <= nxt_slaveAddr;
        end
    end

    // the four channel sets share the access bus, each with its strobe
    generate
        for (genvar g = 0; g < NUM_CHAN; g++)
        begin : gChan
            retimer_channel_set uSet
            (
                .clk    (clk),
                .rst_n  (rstSync_ff),
                .wrEn   (chanWr[g]),
                .addr   (access.addr),
                .wdata  (access.wdata),
                .rdData (chanRd[g]),
                .deemph (deemph[g])
            );
        end
    endgenerate

    // shared set read mux; reserved strap bits read zero
    always_comb
    begin
        unique case (access.addr)
            `OFS_BUS_ADDRESS_STRAP: sharedRd = {strap_ff, 4'h0};
            `OFS_REVISION_AND_PART: sharedRd = REVISION_AND_PART;
            `OFS_SHARED_CONTROL:    sharedRd = control_ff;
            default:                sharedRd = `READ_UNMAPPED;
        endcase
    end

    // read answer one cycle after the request; the select register
    // gives a fixed invalid value, so software cannot rely on it
    always_comb
    begin
        nxt_rdValid = access.rdEn;
        nxt_rdData  = rdData_ff;
        if (access.rdEn)
        begin
            if (access.addr == `OFS_REGISTER_SET_SELECT)
                nxt_rdData = `READ_INVALID;
            else if (chanMode)
                nxt_rdData = chanRd[selChan];
            else
                nxt_rdData = sharedRd;
        end
    end

    always_ff @(posedge clk or negedge rstSync_ff)
    begin
        if (!rstSync_ff)
        begin
            rdData_ff  <= 8'h00;
            rdValid_ff <= 1'b0;
        end
        else
        begin
            rdData_ff  <= nxt_rdData;
            rdValid_ff <= nxt_rdValid;
        end
    end

    assign rdData      = rdData_ff;
    assign rdValid     = rdValid_ff;
    assign slaveAddr   = slaveAddr_ff;
    assign selectState = select_ff;

endmodule

/* verif/smbus_host_model.sv */
// host-side model: issues single-byte register accesses to the bank
// assumes one caller at a time and accesses launched after reset release
`timescale 1ns/1ps

module smbus_host_model
    import retimer_pkg::*;
(
    input  wire logic       clk,
    input  wire logic       rdValid,
    input  wire logic [7:0] rdData,
    output regAccess_s      access
);
    initial access = '0;

    // one write; after release the address and data are inverted so a
    // stale value can never pass for a held one
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        access <= '{1'b1, 1'b0, a, d};
        @(posedge clk);
        access <= '{1'b0, 1'b0, ~a, ~d};
    endtask

    // one read; answer taken while the one-cycle valid pulse stands
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk);
        access <= '{1'b0, 1'b1, a, 8'h00};
        @(posedge clk);
        access <= '{1'b0, 1'b0, ~a, 8'hff};
        #1;
        d = rdValid ? rdData : 8'hxx;
    endtask
endmodule

/* verif/retimer_regs_assertions.sv */
// checker for the retimer register bank, sees only the top-level ports
// assumes the bind below and the single clk domain
`timescale 1ns/1ps

module retimer_regs_checker
    import retimer_pkg::*;
(
    input  wire logic       clk,
    input  wire logic       arst_n,
    input  regAccess_s      access,
    input  wire logic [3:0] addrStrapPin,
    input  wire logic [7:0] rdData,
    input  wire logic       rdValid,
    input  wire logic [6:0] slaveAddr,
    input  wire logic [7:0] selectState,
    input  deemph_s   [3:0] deemph
);
    // depth tables in tenths of a dB, code 7 in the top byte
    localparam logic [63:0] NEAR_T = {8'h38, 8'h2d, 8'h27, 8'h21,
                                      8'h1c, 8'h14, 8'h09, 8'h00};
    localparam logic [63:0] FAR_T  = {8'h78, 8'h5a, 8'h4b, 8'h3c,
                                      8'h32, 8'h23, 8'h0f, 8'h00};
    logic nearOk;
    logic farOk;

    // every channel whose range bit matches must show the table depth
    function automatic logic tblOk(input logic rng, input deemph_s [3:0] d);
        logic ok;
        ok = 1'b1;
        for (int i = 0; i < 4; i++)
            if (d[i].range == rng)
                ok &= d[i].tenthsDb == (rng ? NEAR_T[d[i].code*8 +: 8]
                                            : FAR_T[d[i].code*8 +: 8]);
        return ok;
    endfunction

    assign nearOk = tblOk(1'b1, deemph);
    assign farOk  = tblOk(1'b0, deemph);

    default clocking cb @(posedge clk); endclocking
    default disable iff (!arst_n);

    read_answer_a: assert property (access.rdEn |=> rdValid)
        else $error("read not answered next cycle");
    valid_cause_a: assert property (rdValid |-> $past(access.rdEn))
        else $error("read valid without a read");
    select_write_a: assert property (access.wrEn
        && access.addr == 8'hff
        |=> selectState == $past(access.wdata))
        else $error("select write did not land");
    select_hold_a: assert property (!$stable(selectState) |->
        $past(access.wrEn) || $past(access.wrEn, 2) || $past(access.wrEn, 3))
        else $error("select changed without a write");
    strap_addr_a: assert property ($stable(addrStrapPin)[*8]
        |-> slaveAddr == 7'h18 + {3'h0, addrStrapPin})
        else $error("slave address not base plus strap");
    near_depth_a: assert property (nearOk)
        else $error("narrow range depth wrong");
    far_depth_a: assert property (farOk)
        else $error("wide range depth wrong");
    chan_write_a: assert property (access.wrEn
        && access.addr == 8'h15
        && selectState[2] |=> deemph[selectState[1:0]].code ==
        $past(access.wdata[2:0]))
        else $error("selected channel code not written");
    bcast_write_a: assert property (access.wrEn
        && access.addr == 8'h15
        && selectState[3:2] == 2'h3 |=> deemph[0].code == deemph[3].code
        && deemph[1].code == deemph[2].code
        && deemph[0].code == $past(access.wdata[2:0]))
        else $error("broadcast did not reach all channels");
    shared_mode_a: assert property (access.wrEn && !selectState[2]
        |=> $stable(deemph))
        else $error("shared-mode write reached a channel");
endmodule

bind retimer_shared_channel_regs retimer_regs_checker chk (
    .clk(clk), .arst_n(arst_n), .access(access),
    .addrStrapPin(addrStrapPin), .rdData(rdData), .rdValid(rdValid),
    .slaveAddr(slaveAddr), .selectState(selectState), .deemph(deemph));

/* verif/retimer_shared_channel_regs_tb_top.sv */
// self-checking bench for the retimer register bank
// assumes the host model and the bound checker are compiled alongside
`timescale 1ns/1ps

module retimer_shared_channel_regs_tb_top
    import retimer_pkg::*;
;
    logic            clk = 1'b0;
    logic            arst_n = 1'b0;
    logic [3:0]      addrStrapPin = 4'h9;
    regAccess_s      access;
    logic [7:0]      rdData;
    logic [7:0]      d;
    logic            rdValid;
    logic [6:0]      slaveAddr;
    logic [7:0]      selectState;
    deemph_s [3:0]   deemph;
    int              badCount = 0;
    int              numChecks = 0;
    int              cycles = 0;
    // depth rank of each setting; entry i is range i[3], code i[2:0]
    localparam logic [63:0] IDX_T = 64'ha875_4310_edcb_9620;

    always #50 clk = ~clk;

    retimer_shared_channel_regs uut (.clk(clk), .arst_n(arst_n),
        .access(access), .addrStrapPin(addrStrapPin), .rdData(rdData),
        .rdValid(rdValid), .slaveAddr(slaveAddr),
        .selectState(selectState), .deemph(deemph));
    smbus_host_model host (.clk(clk), .rdValid(rdValid), .rdData(rdData),
        .access(access));

    task automatic tallyAndFinish;
        if (badCount == 0 && numChecks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    task automatic chk(input string w, input logic [7:0] e,
                       input logic [7:0] s);
        numChecks++;
        if (s !== e)
        begin
            badCount++;
            $display("[FAIL] %s expected %h seen %h", w, e, s);
        end
    endtask

    // read one offset and compare the answer
    task automatic rdChk(input string w, input logic [7:0] a,
                         input logic [7:0] e);
        logic [7:0] v;
        host.rd(a, v);
        chk(w, e, v);
    endtask

    task automatic settle;
        @(posedge clk);
        #1;
    endtask

    // hang guard: fewer than two hundred cycles are expected
    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 3000)
        begin
            badCount++;
            tallyAndFinish;
        end
    end

    initial
    begin
        repeat (4) @(posedge clk);
        arst_n <= 1'b1;
        repeat (10) @(posedge clk);
        chk("slaveAddr", 8'h21, {1'b0, slaveAddr});
        rdChk("strap", 8'h00, 8'h90);
        rdChk("ident", 8'h01, 8'h5a);
        host.wr(8'h00, 8'h3c);
        host.wr(8'h01, 8'hc3);
        rdChk("strap ro", 8'h00, 8'h90);
        rdChk("ident ro", 8'h01, 8'h5a);
        rdChk("unmapped", 8'h02, 8'h00);
        // a distinct scratch byte per channel, then read each back
        for (int ch = 0; ch < 4; ch++)
        begin
            host.wr(8'hff, 8'h04 | ch[7:0]);
            host.wr(8'h00, 8'h10 + ch[7:0]);
        end
        for (int ch = 0; ch < 4; ch++)
        begin
            host.wr(8'hff, 8'h04 | ch[7:0]);
            settle;
            chk("select", 8'h04 | ch[7:0], selectState);
            rdChk("scratch", 8'h00, 8'h10 + ch[7:0]);
        end
        // every code under both ranges on channel 3
        for (int i = 0; i < 16; i++)
        begin
            host.wr(8'h15, {1'b0, i[3], 3'h0, i[2:0]});
            settle;
            chk("deemph", {1'b0, i[3], 3'h0, i[2:0]},
                {1'b0, deemph[3].range, 3'h0, deemph[3].code});
            chk("index", {4'h0, IDX_T[i*4 +: 4]},
                {4'h0, deemph[3].index});
        end
        chk("ch0 idle", 8'h00, {5'h0, deemph[0].code});
        rdChk("deemph rd", 8'h15, 8'h47);
        // partial update: clear the range bit only
        host.rd(8'h15, d);
        host.wr(8'h15, d & 8'hbf);
        rdChk("rmw", 8'h15, 8'h07);
        // broadcast, then reads follow the numbered channel only
        host.wr(8'hff, 8'h0d);
        host.wr(8'h15, 8'h43);
        host.wr(8'h00, 8'ha5);
        settle;
        for (int ch = 0; ch < 4; ch++)
            chk("bcast", 8'h43,
                {1'b0, deemph[ch].range, 3'h0, deemph[ch].code});
        host.wr(8'hff, 8'h06);
        host.wr(8'h00, 8'h5a);
        host.wr(8'hff, 8'h0d);
        rdChk("bcast rd1", 8'h00, 8'ha5);
        host.wr(8'hff, 8'h0e);
        rdChk("bcast rd2", 8'h00, 8'h5a);
        // back to shared; broadcast bit alone must not route to channels
        host.wr(8'hff, 8'h08);
        rdChk("shared", 8'h00, 8'h90);
        rdChk("select rd", 8'hff, 8'h00);
        host.wr(8'h04, 8'h21);
        repeat (2) settle;
        rdChk("ctrl sc", 8'h04, 8'h01);
        host.wr(8'h04, 8'h41);
        repeat (3) settle;
        chk("select rst", 8'h00, selectState);
        // the strap pins move: address and strap register must follow
        @(posedge clk);
        addrStrapPin <= 4'h6;
        repeat (5) settle;
        chk("slaveAddr2", 8'h1e, {1'b0, slaveAddr});
        rdChk("strap2", 8'h00, 8'h60);
        tallyAndFinish;
    end
endmodule
